// file: mamd_core.sv
`timescale 1ns/10ps
module mamd_core (
  // clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  // program memory, one cycle read latency
  output mamd_pkg::mamd_pmem_req_t        pmem_req_o,
  input  wire logic [mamd_pkg::BYTE_W-1:0] pmem_rdata_i,
  // data space memory, one cycle read latency
  output mamd_pkg::mamd_dmem_req_t        dmem_req_o,
  input  wire logic [mamd_pkg::BYTE_W-1:0] dmem_rdata_i,
  // core status
  output mamd_pkg::mamd_stat_t            stat_o
);
  import mamd_pkg::*;

  typedef enum logic [2:0] {
    S_BOOT, S_OPC, S_B2, S_B3, S_DRD, S_DCAP, S_WR, S_PAD
  } mamd_state_t;

  mamd_state_t       state_q, state_d, nxt;
  mamd_mode_t        mode_q, dec_mode, cur_mode;
  logic [CNT_W-1:0]  cnt_q, len_q, dec_len;
  logic [BYTE_W-1:0] op_q, cur, acc_q, dadr_q;
  logic [BYTE_W-1:0] wdat_q, rdat, int_rd, bmask;
  logic [BYTE_W-1:0] ptr_q [SD_NUM];
  logic [PA_W-1:0]   fp_q, ipc_q, stk_top;
  logic [PA_W-1:0]   rel_tgt, ext_tgt, span_w;
  logic              z_q, c_q, retire_q, illegal_q, dec_ill, fin;
  logic              at_end, fetch_go, pm_more, is_st, rel_take, int_hit;
  logic              tbit, btb_take, wr_int, ld_cap, is_ret, is_call, opc_now;

  // the opcode is consumed straight off the memory bus in S_OPC, then held
  assign opc_now  = (state_q == S_OPC);
  assign cur      = opc_now ? pmem_rdata_i : op_q;
  assign cur_mode = opc_now ? dec_mode : mode_q;

  always_comb begin
    dec_ill  = 1'b0;
    dec_mode = M_INH;
    dec_len  = CYC_INH;
    if (!pmem_rdata_i[7]) begin
      dec_mode = M_REL;
      dec_len  = CYC_BR;
    end else begin
      case (pmem_rdata_i[7:4])
        GRP_JP, GRP_CALL: begin
          dec_mode = M_EXT;
          dec_len  = CYC_EXT;
        end
        GRP_BIT: begin
          dec_mode = M_BITD;
          dec_len  = CYC_BIT;
        end
        GRP_BTB: begin
          dec_mode = M_BTB;
          dec_len  = CYC_BTB;
        end
        GRP_LS0, GRP_LS1: begin
          dec_len = CYC_LDST;
          case (pmem_rdata_i[3:0])
            LS_LD_IND, LS_ST_IND: dec_mode = M_IND;
            LS_LD_DIR, LS_ST_DIR: dec_mode = M_DIR;
            LS_LDI_A, LS_LDI_RR:  dec_mode = M_IMM;
            LS_RET, LS_NOP: begin
              dec_mode = M_INH;
              dec_len  = CYC_INH;
            end
            default: dec_mode = M_SDIR;
          endcase
          // bit 4 only means something for the indirect pair
          if (pmem_rdata_i[4] && dec_mode != M_IND) begin
            dec_ill  = 1'b1;
            dec_mode = M_INH;
            dec_len  = CYC_INH;
          end
        end
        default: dec_ill = 1'b1;
      endcase
    end
  end

  assign is_st   = (cur_mode == M_SDIR) ? cur[2] : cur[0];
  assign is_ret  = opc_now && !dec_ill && dec_mode == M_INH && cur[3:0] == LS_RET;
  assign is_call = (state_q == S_B2) && cur_mode == M_EXT && cur[7:4] == GRP_CALL;
  assign at_end  = (cnt_q == len_q - 3'h1);

  always_comb begin
    nxt = S_PAD;
    fin = 1'b0;
    case (state_q)
      S_OPC: begin
        case (cur_mode)
          M_REL, M_INH:  fin = 1'b1;
          M_SDIR, M_IND: nxt = is_st ? S_WR : S_DRD;
          default:       nxt = S_B2;
        endcase
      end
      S_B2: begin
        case (cur_mode)
          M_EXT:  fin = 1'b1;
          M_IMM: begin
            if (is_st) begin
              nxt = S_B3;
            end else begin
              fin = 1'b1;
            end
          end
          M_DIR:  nxt = is_st ? S_WR : S_DRD;
          M_BITD: nxt = S_DRD;
          default: nxt = S_B3;
        endcase
      end
      S_B3:   nxt = (cur_mode == M_BTB) ? S_DCAP : S_WR;
      S_DRD:  nxt = S_DCAP;
      S_DCAP: begin
        if (cur_mode == M_BITD) begin
          nxt = S_WR;
        end else begin
          fin = 1'b1;
        end
      end
      S_WR, S_PAD: fin = 1'b1;
      default: nxt = S_PAD;
    endcase
  end

  // next opcode is fetched in the instruction's last cycle, so the counter
  // pads short sequences out to their fixed length
  assign fetch_go = (state_q == S_BOOT) || (fin && at_end);
  assign pm_more  = (opc_now || state_q == S_B2) && (nxt == S_B2 || nxt == S_B3);
  assign state_d  = fetch_go ? S_OPC : (fin ? S_PAD : nxt);

  assign rel_take = cur[6] ? (c_q == cur[5]) : (z_q == cur[5]);
  assign span_w   = {8'h00, cur[3:0]};
  assign rel_tgt  = cur[4] ? fp_q - 12'h001 - span_w : fp_q + span_w;
  assign ext_tgt  = {cur[3:0], pmem_rdata_i};

  // accumulator and the four short registers live here, not in data memory
  assign int_hit  = (dadr_q[7:2] == SD_BASE[7:2]) || (dadr_q == ACC_ADDR);
  assign int_rd   = (dadr_q == ACC_ADDR) ? acc_q : ptr_q[dadr_q[1:0]];
  assign rdat     = int_hit ? int_rd : dmem_rdata_i;
  assign bmask    = 8'h01 << cur[2:0];
  assign tbit     = |(rdat & bmask);
  assign btb_take = (tbit == cur[3]);
  assign wr_int   = (state_q == S_WR) && int_hit;
  assign ld_cap   = (state_q == S_DCAP) && (cur_mode inside {M_DIR, M_SDIR, M_IND});

  assign pmem_req_o.rd    = fetch_go || pm_more;
  assign pmem_req_o.addr  = fp_q;
  assign dmem_req_o.re    = !int_hit && (state_q == S_DRD || (state_q == S_B3 && cur_mode == M_BTB));
  assign dmem_req_o.we    = (state_q == S_WR) && !int_hit;
  assign dmem_req_o.addr  = dadr_q;
  assign dmem_req_o.wdata = wdat_q;

  assign stat_o.retire  = retire_q;
  assign stat_o.illegal = illegal_q;
  assign stat_o.mode    = mode_q;
  assign stat_o.zero    = z_q;
  assign stat_o.carry   = c_q;
  assign stat_o.acc     = acc_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= S_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      len_q <= CYC_INH;
      op_q  <= ZERO_B;
      mode_q <= M_INH;
    end else begin
      cnt_q <= fetch_go ? '0 : cnt_q + 3'h1;
      if (opc_now) begin
        op_q   <= pmem_rdata_i;
        mode_q <= dec_mode;
        len_q  <= dec_len;
      end
    end
  end

  // program counter: fp_q always points at the next program byte to read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fp_q  <= PROG_START;
      ipc_q <= PROG_START;
    end else begin
      if (fetch_go) begin
        ipc_q <= fp_q;
      end
      if (opc_now && cur_mode == M_REL && rel_take) begin
        fp_q <= rel_tgt;
      end else if (is_ret) begin
        fp_q <= stk_top;
      end else if (state_q == S_B2 && cur_mode == M_EXT) begin
        fp_q <= ext_tgt;
      end else if (state_q == S_DCAP && cur_mode == M_BTB && btb_take) begin
        fp_q <= fp_q + {{4{wdat_q[7]}}, wdat_q};
      end else if (pmem_req_o.rd) begin
        fp_q <= fp_q + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dadr_q <= ZERO_B;
      wdat_q <= ZERO_B;
    end else begin
      case (state_q)
        S_OPC: begin
          wdat_q <= acc_q;
          if (cur_mode == M_SDIR) begin
            dadr_q <= SD_BASE | {6'h00, cur[1:0]};
          end else if (cur_mode == M_IND) begin
            dadr_q <= ptr_q[{1'b0, cur[4]}];
          end
        end
        S_B2: begin
          if (cur_mode != M_EXT) begin
            dadr_q <= pmem_rdata_i;
          end
        end
        S_B3: wdat_q <= pmem_rdata_i;
        S_DCAP: begin
          if (cur_mode == M_BITD) begin
            wdat_q <= cur[3] ? (rdat | bmask) : (rdat & ~bmask);
          end
        end
        default: wdat_q <= wdat_q;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      acc_q <= ZERO_B;
      for (int i = 0; i < SD_NUM; i++) begin
        ptr_q[i] <= ZERO_B;
      end
    end else begin
      if (state_q == S_B2 && cur_mode == M_IMM && !is_st) begin
        acc_q <= pmem_rdata_i;
      end else if (ld_cap) begin
        acc_q <= rdat;
      end else if (wr_int && dadr_q == ACC_ADDR) begin
        acc_q <= wdat_q;
      end
      if (wr_int && dadr_q != ACC_ADDR) begin
        ptr_q[dadr_q[1:0]] <= wdat_q;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      z_q <= 1'b0;
    end else if (state_q == S_B2 && cur_mode == M_IMM && !is_st) begin
      z_q <= (pmem_rdata_i == ZERO_B);
    end else if (ld_cap) begin
      z_q <= (rdat == ZERO_B);
    end else if (state_q == S_WR && (cur_mode inside {M_DIR, M_SDIR, M_IND})) begin
      z_q <= (wdat_q == ZERO_B);
    end
  end

  // only bit test branch moves carry; loads and stores leave it alone
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      c_q <= 1'b0;
    end else if (state_q == S_DCAP && cur_mode == M_BTB) begin
      c_q <= tbit;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      retire_q  <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      retire_q  <= fetch_go && state_q != S_BOOT;
      illegal_q <= opc_now && dec_ill;
    end
  end

  mamd_stack u_stack (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .push_i      (is_call),
    .pop_i       (is_ret),
    .push_addr_i (fp_q),
    .top_addr_o  (stk_top)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ldst_len_a: assert property (
    (opc_now && !dec_ill && dec_mode inside {M_SDIR, M_DIR, M_IND, M_IMM})
      |-> !fetch_go [*3] ##1 fetch_go)
    else $error("load or store not four cycles");

  rel_len_a: assert property (
    (opc_now && dec_mode == M_REL) |-> ##1 fetch_go ##1 (state_q == S_OPC))
    else $error("relative branch not two cycles");

  rel_fwd_a: assert property (
    (opc_now && dec_mode == M_REL && rel_take && !pmem_rdata_i[4])
      |=> fp_q == ipc_q + 12'h001 + $past(span_w))
    else $error("forward branch target wrong");

  rel_back_a: assert property (
    (opc_now && dec_mode == M_REL && rel_take && pmem_rdata_i[4]) |=> fp_q == ipc_q - $past(span_w))
    else $error("backward branch target wrong");

  rel_skip_a: assert property (
    (opc_now && dec_mode == M_REL && !rel_take) |=> fp_q == ipc_q + 12'h001)
    else $error("untaken branch did not fall through");

  ext_tgt_a: assert property (
    (state_q == S_B2 && mode_q == M_EXT) |=> fp_q == $past(ext_tgt))
    else $error("extended target wrong");

  imm_acc_a: assert property (
    (state_q == S_B2 && mode_q == M_IMM && !op_q[0]) |=> acc_q == $past(pmem_rdata_i))
    else $error("immediate operand not loaded");

  zero_load_a: assert property (
    ld_cap |=> (z_q == (acc_q == ZERO_B)))
    else $error("zero flag does not match loaded byte");

  carry_hold_a: assert property (
    !(state_q == S_DCAP && mode_q == M_BTB) |=> $stable(c_q))
    else $error("carry changed outside bit test");

  ldi_rr_z_a: assert property (
    (opc_now && dec_mode == M_IMM && pmem_rdata_i[0]) |=> $stable(z_q) [*4])
    else $error("register load_immediate touched zero flag");

  ind_sel_a: assert property (
    (opc_now && dec_mode == M_IND) |=> dadr_q == ptr_q[{1'b0, op_q[4]}])
    else $error("indirect pointer selection wrong");

  sdir_addr_a: assert property (
    (opc_now && dec_mode == M_SDIR) |=> dadr_q == (SD_BASE | {6'h00, op_q[1:0]}))
    else $error("short direct address wrong");

  btb_len_a: assert property (
    (opc_now && dec_mode == M_BTB) |-> ##5 (state_q == S_OPC))
    else $error("bit test branch not five cycles");

  load_dir_c: cover property (stat_o.retire && mode_q == M_DIR && !op_q[0]);
  btb_take_c: cover property (state_q == S_DCAP && mode_q == M_BTB && btb_take);
  call_ret_c: cover property (is_call ##[1:40] is_ret);
  illegal_c:  cover property (stat_o.illegal);

endmodule // mamd_core

// file: mamd_pkg.sv
package mamd_pkg;
  // Function
  // - separate program, data and stack spaces; stack holds six 12-bit return addresses
  // - program space supplies instructions and immediate operands from one read-only memory
  // - data space maps accumulator, four pointer/scratch registers, peripherals, ram, rom
  // - immediate operand is the last program byte: right after the opcode, or after the address byte in the register form
  // - direct mode takes an 8-bit data address from the byte after the opcode
  // - short direct opcode selects one of data locations 80h to 83h
  // - extended mode joins low opcode nibble and next byte into 12-bit target
  // - relative branch is one byte, range -15 to +16, else falls through
  // - relative opcode holds condition, direction bit and a 4-bit span
  // - bit direct opcode names the bit, next byte names the data address
  // - bit test branch is three bytes with signed displacement -128 to +127
  // - indirect address comes from pointer_one or pointer_two, chosen by opcode bit 4
  // - inherent instructions are one byte and need nothing beyond the opcode
  // - decoder sorts opcodes into nine addressing modes and six instruction groups
  // - load always moves between accumulator and a data location
  // - load_immediate reaches any data byte; register form is three bytes, flags kept
  // - load and store take four cycles, update zero, never touch carry
  localparam int BYTE_W    = 8;
  localparam int PA_W      = 12;
  localparam int STK_DEPTH = 6;
  localparam int SP_W      = 3;
  localparam int CNT_W     = 3;
  localparam int SD_NUM    = 4;

  localparam logic [PA_W-1:0]   PROG_START = 12'h000;
  localparam logic [BYTE_W-1:0] SD_BASE    = 8'h80;
  localparam logic [BYTE_W-1:0] ACC_ADDR   = 8'hff;
  localparam logic [BYTE_W-1:0] ZERO_B     = 8'h00;

  // opcode high nibble groups; 00h-7fh are relative branches
  localparam logic [3:0] GRP_JP   = 4'h8;
  localparam logic [3:0] GRP_CALL = 4'h9;
  localparam logic [3:0] GRP_BIT  = 4'ha;
  localparam logic [3:0] GRP_BTB  = 4'hb;
  localparam logic [3:0] GRP_LS0  = 4'hc;
  localparam logic [3:0] GRP_LS1  = 4'hd;

  // low nibble of the load/store groups; 0-3 load short, 4-7 store short
  localparam logic [3:0] LS_LD_DIR = 4'h8;
  localparam logic [3:0] LS_ST_DIR = 4'h9;
  localparam logic [3:0] LS_LD_IND = 4'ha;
  localparam logic [3:0] LS_ST_IND = 4'hb;
  localparam logic [3:0] LS_LDI_A  = 4'hc;
  localparam logic [3:0] LS_LDI_RR = 4'hd;
  localparam logic [3:0] LS_RET    = 4'he;
  localparam logic [3:0] LS_NOP    = 4'hf;

  // instruction lengths in core clock cycles
  localparam logic [CNT_W-1:0] CYC_LDST = 3'h4;
  localparam logic [CNT_W-1:0] CYC_BR   = 3'h2;
  localparam logic [CNT_W-1:0] CYC_EXT  = 3'h4;
  localparam logic [CNT_W-1:0] CYC_BIT  = 3'h5;
  localparam logic [CNT_W-1:0] CYC_BTB  = 3'h5;
  localparam logic [CNT_W-1:0] CYC_INH  = 3'h2;

  typedef enum logic [3:0] {
    M_IMM, M_DIR, M_SDIR, M_EXT, M_REL, M_BITD, M_BTB, M_IND, M_INH
  } mamd_mode_t;

  typedef struct packed {
    logic            rd;
    logic [PA_W-1:0] addr;
  } mamd_pmem_req_t;

  typedef struct packed {
    logic              re;
    logic              we;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } mamd_dmem_req_t;

  typedef struct packed {
    logic              retire;
    logic              illegal;
    mamd_mode_t        mode;
    logic              zero;
    logic              carry;
    logic [BYTE_W-1:0] acc;
  } mamd_stat_t;
endpackage

// file: mamd_stack.sv
`timescale 1ns/10ps
module mamd_stack (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  // push and pop
  input  wire logic                     push_i,
  input  wire logic                     pop_i,
  input  wire logic [mamd_pkg::PA_W-1:0] push_addr_i,
  output logic      [mamd_pkg::PA_W-1:0] top_addr_o
);
  import mamd_pkg::*;

  logic [PA_W-1:0] cell_q [STK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] top_idx;

  // circular: a seventh nested call silently overwrites the oldest entry
  assign top_idx    = (sp_q == '0) ? SP_W'(STK_DEPTH - 1) : sp_q - 3'h1;
  assign top_addr_o = cell_q[top_idx];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sp_q <= '0;
    end else if (push_i) begin
      sp_q <= (sp_q == SP_W'(STK_DEPTH - 1)) ? '0 : sp_q + 3'h1;
    end else if (pop_i) begin
      sp_q <= top_idx;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < STK_DEPTH; i++) begin
        cell_q[i] <= PROG_START;
      end
    end else if (push_i) begin
      cell_q[sp_q] <= push_addr_i;
    end
  end

  stk_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    push_i |=> (sp_q < SP_W'(STK_DEPTH)) && (cell_q[$past(sp_q)] == $past(push_addr_i)))
    else $error("stack pointer or pushed entry wrong");

endmodule // mamd_stack

// file: mamd_mem_model.sv
`timescale 1ns/10ps
module mamd_mem_model
  import mamd_pkg::*;
(
  // clock
  input  wire logic                       mclk_i,
  // program memory
  input  wire mamd_pkg::mamd_pmem_req_t   pmem_req_i,
  output logic      [mamd_pkg::BYTE_W-1:0] pmem_rdata_o,
  // data space memory
  input  wire mamd_pkg::mamd_dmem_req_t   dmem_req_i,
  output logic      [mamd_pkg::BYTE_W-1:0] dmem_rdata_o
);
  // the bench loads both arrays directly; the core can only read rom
  logic [BYTE_W-1:0] rom [0:4095];
  logic [BYTE_W-1:0] ram [0:255];

  initial begin
    pmem_rdata_o = 8'h5a;
    dmem_rdata_o = 8'ha5;
  end

  // one cycle latency; between reads the bus toggles so a stale byte is never mistaken for data
  always @(posedge mclk_i) begin
    if (pmem_req_i.rd) begin
      pmem_rdata_o <= rom[pmem_req_i.addr];
    end else begin
      pmem_rdata_o <= ~pmem_rdata_o;
    end
  end

  always @(posedge mclk_i) begin
    if (dmem_req_i.re) begin
      dmem_rdata_o <= ram[dmem_req_i.addr];
    end else begin
      dmem_rdata_o <= ~dmem_rdata_o;
    end
    if (dmem_req_i.we) begin
      ram[dmem_req_i.addr] <= dmem_req_i.wdata;
    end
  end
endmodule // mamd_mem_model

// file: tb_mcu_addressing_mode_decoder.sv
`timescale 1ns/10ps
module tb_mcu_addressing_mode_decoder;
  import mamd_pkg::*;
  logic              mclk_i;
  logic              rst_i;
  mamd_pmem_req_t    pmem_req;
  mamd_dmem_req_t    dmem_req;
  logic [BYTE_W-1:0] pmem_rdata;
  logic [BYTE_W-1:0] dmem_rdata;
  mamd_stat_t        stat;
  int                n_fail = 0;
  int                n_compared = 0;
  int                cyc = 0;

  mamd_core i_mamd_core (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .pmem_req_o   (pmem_req),
    .pmem_rdata_i (pmem_rdata),
    .dmem_req_o   (dmem_req),
    .dmem_rdata_i (dmem_rdata),
    .stat_o       (stat)
  );

  mamd_mem_model i_mamd_mem_model (
    .mclk_i       (mclk_i),
    .pmem_req_i   (pmem_req),
    .pmem_rdata_o (pmem_rdata),
    .dmem_req_i   (dmem_req),
    .dmem_rdata_o (dmem_rdata)
  );

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) cyc <= cyc + 1;

  task automatic wrap_up;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] b[$]);
    foreach (b[i]) i_mamd_mem_model.rom[a + 12'(i)] = b[i];
  endtask

  // empty program space is all nop so a runaway core stays harmless
  task automatic fresh;
    for (int i = 0; i < 4096; i++) i_mamd_mem_model.rom[i] = 8'hcf;
    for (int i = 0; i < 256; i++) i_mamd_mem_model.ram[i] = 8'h00;
  endtask

  task automatic wait_ret(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge mclk_i);
        #1;
        k++;
      end while (stat.retire !== 1'b1 && k < 40);
      check(8'(k < 40), 8'h01);
    end
  endtask

  task automatic run(input int n);
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    wait_ret(n);
  endtask

  task automatic t_imm;
    int t0;
    fresh();
    put(12'h000, '{8'hcc, 8'h00, 8'hcc, 8'h5a});
    run(1);
    t0 = cyc;
    check(stat.acc, 8'h00);
    check(8'(stat.zero), 8'h01);
    check(8'(stat.mode), 8'(M_IMM));
    wait_ret(1);
    check(8'(cyc - t0), 8'h04);
    check(stat.acc, 8'h5a);
    check(8'(stat.zero), 8'h00);
    check(8'(stat.carry), 8'h00);
  endtask

  task automatic t_dir;
    fresh();
    i_mamd_mem_model.ram[8'h30] = 8'ha5;
    put(12'h000, '{8'hc8, 8'h30, 8'hc9, 8'h40});
    run(3);
    check(stat.acc, 8'ha5);
    check(i_mamd_mem_model.ram[8'h40], 8'ha5);
  endtask

  // pointer cells live in the core, so the value must come back without the data bus
  task automatic t_sdir;
    fresh();
    put(12'h000, '{8'hcc, 8'h77, 8'hc6, 8'hcc, 8'h00, 8'hc2});
    run(4);
    check(stat.acc, 8'h77);
    check(8'(stat.zero), 8'h00);
    check(8'(stat.mode), 8'(M_SDIR));
  endtask

  task automatic t_ind;
    fresh();
    i_mamd_mem_model.ram[8'h50] = 8'h3c;
    // zero is set first so that a register load_immediate that touched it would show
    put(12'h000, '{8'hcc, 8'h00, 8'hcd, 8'h80, 8'h50, 8'hcd, 8'h81, 8'h51, 8'hca, 8'hda, 8'hcb});
    run(3);
    check(8'(stat.zero), 8'h01);
    wait_ret(1);
    check(stat.acc, 8'h3c);
    check(8'(stat.mode), 8'(M_IND));
    wait_ret(1);
    check(stat.acc, 8'h00);
    check(8'(stat.zero), 8'h01);
    wait_ret(2);
    check(i_mamd_mem_model.ram[8'h50], 8'h00);
  endtask

  task automatic t_ext;
    fresh();
    // call out and return before the jump, so a wrong return address never reaches 123h
    put(12'h000, '{8'h91, 8'h10, 8'h81, 8'h23});
    put(12'h110, '{8'hce});
    put(12'h123, '{8'hcc, 8'h11});
    run(4);
    check(stat.acc, 8'h11);
  endtask

  task automatic t_rel;
    fresh();
    put(12'h000, '{8'hcc, 8'h00, 8'h23, 8'hcc, 8'h99, 8'hcf, 8'hcc, 8'h44});
    put(12'h008, '{8'hcc, 8'h00, 8'h03, 8'hcc, 8'h55, 8'h13, 8'hcc, 8'h77});
    run(3);
    check(stat.acc, 8'h44);
    wait_ret(3);
    check(stat.acc, 8'h55);
    // backward hop to 00ah, whose branch is now taken forward to 00eh
    wait_ret(3);
    check(stat.acc, 8'h77);
  endtask

  task automatic t_bit;
    fresh();
    put(12'h000, '{8'hab, 8'h21, 8'hbb, 8'h21, 8'h03, 8'hcc, 8'h99, 8'hcf, 8'hcc, 8'h44});
    run(3);
    check(i_mamd_mem_model.ram[8'h21], 8'h08);
    check(stat.acc, 8'h44);
    check(8'(stat.carry), 8'h01);
  endtask

  task automatic t_ill;
    int seen;
    fresh();
    put(12'h000, '{8'hd0});
    seen = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      #1;
      if (stat.illegal === 1'b1) seen = 1;
    end
    check(8'(seen), 8'h01);
  endtask

  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_i = 1'b1;
    fresh();
    repeat (8) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    t_imm();
    t_dir();
    t_sdir();
    t_ind();
    t_ext();
    t_rel();
    t_bit();
    t_ill();
    wrap_up();
  end
endmodule // tb_mcu_addressing_mode_decoder
